// ---- verilog/bpcer_device.sv ----
// device end: boot partition command decoder, buffers and error correction result registers
//
// Summary of operation
// - main result holds error word offset of 256
// - result holds one-of-16 data line field
// - boot loading also updates all result fields
// - spare position 00 second, 01 third word
// - four read-only result registers, reset zero
// - commands taken only at boot addresses
// - boot data read before any command, and again after 00F0h
// - other writes are plain buffer/register stores
// - execute only after all command cycles
// - bad boot write abandons sequence, back ready
// - 00F0h single cycle restores all defaults unless a load is armed
// - 00E0h then 0000h loads one page
// - page load ignores sector and buffer fields
// - page address increments, wraps inside block
// - block and page fields reset to zero
// - 0090h then read gives maker/device/protection
// - host sets block before identification read
// - any write except 0090h at a boot address ends identification read mode
// - data area read returns stored buffer word
// - data area write stores the word
// - any command clears ecc status and results
// - load done sets sticky flag, cleared by zero
`timescale 1ns/1ps
module bpcer_device (
    input wire logic CLK,
    input wire logic ARST_N,
    bpcer_link_if.device LINK,
    output logic LOAD_REQ,
    output logic [8:0] LOAD_BLOCK,
    output logic [5:0] LOAD_PAGE,
    input wire logic FILL_VALID,
    input wire logic FILL_BOOT,
    input wire logic [9:0] FILL_ADDR,
    input wire logic [15:0] FILL_DATA,
    input wire logic FILL_DONE,
    input wire logic [7:0] ECC_STATUS_IN,
    input wire logic [7:0] FIRST_SECTOR_ERROR_WORD,
    input wire logic [3:0] FIRST_SECTOR_ERROR_LINE,
    input wire logic [1:0] FIRST_SECTOR_SPARE_POSITION,
    input wire logic [7:0] SECOND_SECTOR_ERROR_WORD,
    input wire logic [3:0] SECOND_SECTOR_ERROR_LINE,
    input wire logic [1:0] SECOND_SECTOR_SPARE_POSITION,
    input wire logic [2:0] PROTECT_STATUS
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [15:0] boot_mem [0:bpcer_pkg::BOOT_WORDS-1];
    logic [15:0] first_data_ram [0:bpcer_pkg::DATA_WORDS-1];
    bpcer_pkg::bpcer_state_type state;
    logic cmd_issued;
    logic [bpcer_pkg::BLOCK_W-1:0] flash_block_field;
    logic [bpcer_pkg::PAGE_W-1:0] flash_page_field;
    logic [1:0] flash_sector_field;
    logic [15:0] buffer_reg;
    logic [15:0] int_status;
    logic [7:0] ecc_status;
    logic [15:0] s0_main;
    logic [15:0] s0_spare;
    logic [15:0] s1_main;
    logic [15:0] s1_spare;
    logic [15:0] rdata;
    logic rvalid;

    // ------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------
    logic boot_wr;
    logic data_wr;
    logic do_reset;
    logic do_load;
    logic cmd_cycle;
    logic load_start;
    logic load_end;
    logic boot_end;

    assign boot_wr = LINK.wr && bpcer_pkg::in_boot(LINK.addr);
    assign data_wr = LINK.wr && LINK.addr >= bpcer_pkg::DATA_BEGIN && LINK.addr <= bpcer_pkg::DATA_END;
    assign do_reset = boot_wr && LINK.wdata == bpcer_pkg::CMD_RESET && state != bpcer_pkg::ST_LOAD_ARMED;
    assign load_start = boot_wr && LINK.wdata == bpcer_pkg::CMD_LOAD && state != bpcer_pkg::ST_LOAD_ARMED;
    assign do_load = boot_wr && state == bpcer_pkg::ST_LOAD_ARMED
        && LINK.wdata == bpcer_pkg::CMD_LOAD_CONFIRM;
    assign cmd_cycle = do_reset || load_start || do_load
        || (boot_wr && LINK.wdata == bpcer_pkg::CMD_IDENT && state != bpcer_pkg::ST_LOAD_ARMED);
    assign load_end = FILL_DONE && !FILL_BOOT && state == bpcer_pkg::ST_LOADING;
    assign boot_end = FILL_DONE && FILL_BOOT;

    // ------------------------------------------------------------
    // command sequencer
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state <= bpcer_pkg::ST_READY;
        end else if (state == bpcer_pkg::ST_LOADING) begin
            if (load_end) begin
                state <= bpcer_pkg::ST_READY;
            end
        end else if (boot_wr) begin
            case (state)
                bpcer_pkg::ST_LOAD_ARMED: begin
                    // wrong second cycle abandons the sequence
                    state <= do_load ? bpcer_pkg::ST_LOADING : bpcer_pkg::ST_READY;
                end
                default: begin
                    if (LINK.wdata == bpcer_pkg::CMD_LOAD) begin
                        state <= bpcer_pkg::ST_LOAD_ARMED;
                    end else if (LINK.wdata == bpcer_pkg::CMD_IDENT) begin
                        state <= bpcer_pkg::ST_IDENT;
                    end else begin
                        state <= bpcer_pkg::ST_READY;
                    end
                end
            endcase
        end else if (LINK.wr && state == bpcer_pkg::ST_IDENT) begin
            state <= bpcer_pkg::ST_READY;
        end else if (LINK.wr && state == bpcer_pkg::ST_LOAD_ARMED) begin
            state <= bpcer_pkg::ST_READY;
        end
    end

    // remembers that boot reads now answer the command
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cmd_issued <= 1'b0;
        end else if (do_reset) begin
            cmd_issued <= 1'b0;
        end else if (cmd_cycle) begin
            cmd_issued <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // address and buffer registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            flash_block_field <= '0;
            flash_page_field <= '0;
            flash_sector_field <= '0;
            buffer_reg <= bpcer_pkg::REG_RESET;
        end else if (do_reset) begin
            flash_block_field <= '0;
            flash_page_field <= '0;
            flash_sector_field <= '0;
            buffer_reg <= bpcer_pkg::REG_RESET;
        end else if (load_end) begin
            // six-bit page wraps without touching the block
            flash_page_field <= flash_page_field + 6'h01;
        end else if (LINK.wr && state != bpcer_pkg::ST_LOADING) begin
            if (LINK.addr == bpcer_pkg::ADDR_BLOCK) begin
                flash_block_field <= LINK.wdata[bpcer_pkg::BLOCK_W-1:0];
            end
            if (LINK.addr == bpcer_pkg::ADDR_PAGE) begin
                flash_page_field <= LINK.wdata[bpcer_pkg::PAGE_LSB +: bpcer_pkg::PAGE_W];
                flash_sector_field <= LINK.wdata[1:0];
            end
            if (LINK.addr == bpcer_pkg::ADDR_BUFFER) begin
                buffer_reg <= LINK.wdata;
            end
        end
    end

    // load-done flag: hardware set wins over a software clear
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            int_status <= bpcer_pkg::INT_RESET;
        end else if (load_end || boot_end) begin
            int_status[bpcer_pkg::INT_LOAD_BIT] <= 1'b1;
        end else if (do_reset) begin
            int_status <= bpcer_pkg::INT_RESET;
        end else if (LINK.wr && LINK.addr == bpcer_pkg::ADDR_INT && !LINK.wdata[bpcer_pkg::INT_LOAD_BIT]) begin
            int_status[bpcer_pkg::INT_LOAD_BIT] <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // error correction results
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ecc_status <= 8'h00;
            s0_main <= bpcer_pkg::REG_RESET;
            s0_spare <= bpcer_pkg::REG_RESET;
            s1_main <= bpcer_pkg::REG_RESET;
            s1_spare <= bpcer_pkg::REG_RESET;
        end else if (load_end || boot_end) begin
            // a finished load outranks a clear in the same cycle
            ecc_status <= ECC_STATUS_IN;
            s0_main <= {4'h0, FIRST_SECTOR_ERROR_WORD, FIRST_SECTOR_ERROR_LINE};
            s0_spare <= {10'h000, FIRST_SECTOR_SPARE_POSITION, FIRST_SECTOR_ERROR_LINE};
            s1_main <= {4'h0, SECOND_SECTOR_ERROR_WORD, SECOND_SECTOR_ERROR_LINE};
            s1_spare <= {10'h000, SECOND_SECTOR_SPARE_POSITION, SECOND_SECTOR_ERROR_LINE};
        end else if (cmd_cycle) begin
            ecc_status <= 8'h00;
            s0_main <= bpcer_pkg::REG_RESET;
            s0_spare <= bpcer_pkg::REG_RESET;
            s1_main <= bpcer_pkg::REG_RESET;
            s1_spare <= bpcer_pkg::REG_RESET;
        end
    end

    // ------------------------------------------------------------
    // memories
    // ------------------------------------------------------------
    // boot memory is filled only by boot loading, never by bus writes
    always_ff @(posedge CLK) begin
        if (FILL_VALID && FILL_BOOT && 32'(FILL_ADDR) < bpcer_pkg::BOOT_WORDS) begin
            boot_mem[FILL_ADDR] <= FILL_DATA;
        end
    end

    // first data ram takes fill words and plain bus stores
    always_ff @(posedge CLK) begin
        if (FILL_VALID && !FILL_BOOT) begin
            first_data_ram[FILL_ADDR[8:0]] <= FILL_DATA;
        end else if (data_wr) begin
            first_data_ram[LINK.addr[8:0]] <= LINK.wdata;
        end
    end

    // ------------------------------------------------------------
    // read path, answer one cycle after the strobe
    // ------------------------------------------------------------
    logic [15:0] boot_answer;
    logic [15:0] next_rdata;

    // response seen at boot addresses once a command was given
    always_comb begin
        boot_answer = 16'h0000;
        if (state == bpcer_pkg::ST_IDENT) begin
            if (LINK.addr == bpcer_pkg::ID_OFS_MAKER) begin
                boot_answer = bpcer_pkg::MAKER_CODE;
            end else if (LINK.addr == bpcer_pkg::ID_OFS_DEVICE) begin
                boot_answer = bpcer_pkg::DEVICE_CODE;
            end else if (LINK.addr == bpcer_pkg::ID_OFS_PROTECT) begin
                boot_answer = {13'h0000, PROTECT_STATUS};
            end
        end else begin
            boot_answer[bpcer_pkg::BUSY_BIT] = (state == bpcer_pkg::ST_LOADING);
        end
    end

    // register and buffer read mux
    always_comb begin
        next_rdata = 16'h0000;
        if (bpcer_pkg::in_boot(LINK.addr)) begin
            next_rdata = cmd_issued ? boot_answer : boot_mem[bpcer_pkg::boot_index(LINK.addr)];
        end else if (LINK.addr >= bpcer_pkg::DATA_BEGIN && LINK.addr <= bpcer_pkg::DATA_END) begin
            next_rdata = first_data_ram[LINK.addr[8:0]];
        end else begin
            case (LINK.addr)
                bpcer_pkg::ADDR_BLOCK: next_rdata = {7'h00, flash_block_field};
                bpcer_pkg::ADDR_PAGE: next_rdata = {8'h00, flash_page_field, flash_sector_field};
                bpcer_pkg::ADDR_BUFFER: next_rdata = buffer_reg;
                bpcer_pkg::ADDR_INT: next_rdata = int_status;
                bpcer_pkg::ADDR_WP: next_rdata = {13'h0000, PROTECT_STATUS};
                bpcer_pkg::ADDR_ECC_STATUS: next_rdata = {8'h00, ecc_status};
                bpcer_pkg::ADDR_S0_MAIN: next_rdata = s0_main;
                bpcer_pkg::ADDR_S0_SPARE: next_rdata = s0_spare;
                bpcer_pkg::ADDR_S1_MAIN: next_rdata = s1_main;
                bpcer_pkg::ADDR_S1_SPARE: next_rdata = s1_spare;
                default: next_rdata = 16'h0000;
            endcase
        end
    end

    // registered read data and its valid pulse
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rdata <= 16'h0000;
            rvalid <= 1'b0;
        end else begin
            rvalid <= LINK.rd;
            if (LINK.rd) begin
                rdata <= next_rdata;
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // page request uses block and page only, never sector or buffer settings
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            LOAD_REQ <= 1'b0;
            LOAD_BLOCK <= '0;
            LOAD_PAGE <= '0;
        end else begin
            LOAD_REQ <= do_load;
            if (do_load) begin
                LOAD_BLOCK <= flash_block_field;
                LOAD_PAGE <= flash_page_field;
            end
        end
    end

    assign LINK.rdata = rdata;
    assign LINK.rvalid = rvalid;
    assign LINK.busy = (state == bpcer_pkg::ST_LOADING);
endmodule : bpcer_device

// ---- verilog/bpcer_pkg.sv ----
// package: constants, address map and types shared by both ends of the boot partition command link
package bpcer_pkg;
    // ------------------------------------------------------------
    // address map of the device
    // ------------------------------------------------------------
    localparam logic [15:0] BOOT_LO_BEGIN = 16'h0000;
    localparam logic [15:0] BOOT_LO_END = 16'h01ff;
    localparam logic [15:0] BOOT_HI_BEGIN = 16'h8000;
    localparam logic [15:0] BOOT_HI_END = 16'h800f;
    localparam logic [15:0] DATA_BEGIN = 16'h0200;
    localparam logic [15:0] DATA_END = 16'h03ff;
    localparam logic [15:0] ADDR_BLOCK = 16'hf100;
    localparam logic [15:0] ADDR_PAGE = 16'hf107;
    localparam logic [15:0] ADDR_BUFFER = 16'hf200;
    localparam logic [15:0] ADDR_INT = 16'hf241;
    localparam logic [15:0] ADDR_WP = 16'hf24e;
    localparam logic [15:0] ADDR_ECC_STATUS = 16'hff00;
    localparam logic [15:0] ADDR_S0_MAIN = 16'hff01;
    localparam logic [15:0] ADDR_S0_SPARE = 16'hff02;
    localparam logic [15:0] ADDR_S1_MAIN = 16'hff03;
    localparam logic [15:0] ADDR_S1_SPARE = 16'hff04;
    localparam int BOOT_LO_WORDS = 512;
    localparam int BOOT_WORDS = 528;
    localparam int DATA_WORDS = 512;
    // ------------------------------------------------------------
    // commands and identification
    // ------------------------------------------------------------
    localparam logic [15:0] CMD_RESET = 16'h00f0;
    localparam logic [15:0] CMD_LOAD = 16'h00e0;
    localparam logic [15:0] CMD_LOAD_CONFIRM = 16'h0000;
    localparam logic [15:0] CMD_IDENT = 16'h0090;
    localparam logic [15:0] ID_OFS_MAKER = 16'h0000;
    localparam logic [15:0] ID_OFS_DEVICE = 16'h0001;
    localparam logic [15:0] ID_OFS_PROTECT = 16'h0002;
    localparam logic [15:0] MAKER_CODE = 16'h00a5; // arbitrary value
    localparam logic [15:0] DEVICE_CODE = 16'h0011; // arbitrary value
    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int BLOCK_W = 9;
    localparam int PAGE_W = 6;
    localparam int PAGE_LSB = 2;
    localparam int INT_LOAD_BIT = 7;
    localparam int BUSY_BIT = 15;
    localparam int WORD_LSB = 4;
    localparam int SPARE_LSB = 4;
    localparam logic [15:0] INT_RESET = 16'h0080;
    localparam logic [15:0] REG_RESET = 16'h0000;
    // ------------------------------------------------------------
    // host register map (apb byte offsets)
    // ------------------------------------------------------------
    localparam logic [11:0] HREG_ADDR = 12'h000;
    localparam logic [11:0] HREG_WRITE = 12'h004;
    localparam logic [11:0] HREG_READ = 12'h008;
    localparam logic [11:0] HREG_STATUS = 12'h00c;

    typedef enum logic [1:0] {ST_READY, ST_LOAD_ARMED, ST_IDENT, ST_LOADING} bpcer_state_type;

    // true for an address inside the boot partition
    function automatic logic in_boot(input logic [15:0] a);
        in_boot = (a <= BOOT_LO_END) || (a >= BOOT_HI_BEGIN && a <= BOOT_HI_END);
    endfunction : in_boot

    // index of a boot partition word in the boot memory
    function automatic logic [9:0] boot_index(input logic [15:0] a);
        boot_index = (a <= BOOT_LO_END) ? a[9:0] : 10'(BOOT_LO_WORDS) + {6'h00, a[3:0]};
    endfunction : boot_index
endpackage : bpcer_pkg

// ---- verilog/bpcer_link_if.sv ----
// interface: synchronous parallel bus between host controller and device
`timescale 1ns/1ps
interface bpcer_link_if;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic [15:0] rdata;
    logic rvalid;
    logic busy;

    modport device (input addr, input wdata, input wr, input rd, output rdata, output rvalid, output busy);
    modport host (output addr, output wdata, output wr, output rd, input rdata, input rvalid, input busy);
endinterface : bpcer_link_if

// ---- verilog/bpcer_host.sv ----
// host end: apb slave that turns register writes into device bus cycles
`timescale 1ns/1ps
module bpcer_host (
    input wire logic CLK,
    input wire logic ARST_N,
    bpcer_link_if.host LINK,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR
);
    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic pending;
    logic [15:0] read_data;
    logic access;
    logic mapped;

    assign access = PSEL && PENABLE;
    assign mapped = PADDR == bpcer_pkg::HREG_ADDR || PADDR == bpcer_pkg::HREG_WRITE
        || PADDR == bpcer_pkg::HREG_READ || PADDR == bpcer_pkg::HREG_STATUS;
    assign PREADY = 1'b1;
    assign PSLVERR = access && !mapped;

    // device address register
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            addr <= 16'h0000;
        end else if (access && PWRITE && PADDR == bpcer_pkg::HREG_ADDR) begin
            addr <= PWDATA[15:0];
        end
    end

    // write launch: one bus write cycle per apb write to the data register
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wdata <= 16'h0000;
            wr <= 1'b0;
        end else begin
            wr <= access && PWRITE && PADDR == bpcer_pkg::HREG_WRITE;
            if (access && PWRITE && PADDR == bpcer_pkg::HREG_WRITE) begin
                wdata <= PWDATA[15:0];
            end
        end
    end

    // read launch and capture; a new launch while pending is dropped
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rd <= 1'b0;
            pending <= 1'b0;
            read_data <= 16'h0000;
        end else begin
            rd <= access && PWRITE && PADDR == bpcer_pkg::HREG_READ && !pending;
            if (LINK.rvalid) begin
                pending <= 1'b0;
                read_data <= LINK.rdata;
            end else if (access && PWRITE && PADDR == bpcer_pkg::HREG_READ) begin
                pending <= 1'b1;
            end
        end
    end

    // apb read mux
    always_comb begin
        case (PADDR)
            bpcer_pkg::HREG_ADDR: PRDATA = {16'h0000, addr};
            bpcer_pkg::HREG_WRITE: PRDATA = {16'h0000, wdata};
            bpcer_pkg::HREG_READ: PRDATA = {16'h0000, read_data};
            bpcer_pkg::HREG_STATUS: PRDATA = {30'h00000000, LINK.busy, pending};
            default: PRDATA = 32'h00000000;
        endcase
    end

    assign LINK.addr = addr;
    assign LINK.wdata = wdata;
    assign LINK.wr = wr;
    assign LINK.rd = rd;
endmodule : bpcer_host

// ---- test/bpcer_link_monitor.sv ----
// checker: command and answer relations on the host to device link
`timescale 1ns/1ps
module bpcer_link_monitor (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic [15:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [15:0] rdata,
    input wire logic rvalid,
    input wire logic busy
);
    logic boot;
    logic armed;
    logic ident;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!ARST_N);
    // boot partition decode
    assign boot = addr <= 16'h01ff || (addr >= 16'h8000 && addr <= 16'h800f);
    // open load arm, ended by any write, and identification mode, ended by any write other than 0090h at a boot address
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            armed <= 1'b0;
            ident <= 1'b0;
        end else if (wr) begin
            armed <= boot && !busy && !armed && wdata == 16'h00e0;
            ident <= boot && !busy && !armed && wdata == 16'h0090;
        end
    end
    property p_answer;
        rd |=> rvalid;
    endproperty
    a_answer: assert property (p_answer) else $error("read not answered");
    property p_cause;
        rvalid |-> $past(rd);
    endproperty
    a_cause: assert property (p_cause) else $error("answer without read");
    property p_hold;
        !rvalid |-> $stable(rdata);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_start;
        wr && armed && boot && wdata == 16'h0000 |=> busy;
    endproperty
    a_start: assert property (p_start) else $error("load not started");
    property p_single;
        wr && boot && !busy && (wdata == 16'h00e0 || (wdata == 16'h0000 && !armed)) |=> !busy;
    endproperty
    a_single: assert property (p_single) else $error("load before all cycles");
    property p_abandon;
        wr && armed && !(boot && (wdata == 16'h0000 || wdata == 16'h00e0)) |=> !busy [*2];
    endproperty
    a_abandon: assert property (p_abandon) else $error("sequence not abandoned");
    property p_outside;
        wr && !boot && !busy |=> !busy;
    endproperty
    a_outside: assert property (p_outside) else $error("store taken as command");
    property p_maker;
        rd && ident && addr == 16'h0000 |=> rvalid && rdata == bpcer_pkg::MAKER_CODE;
    endproperty
    a_maker: assert property (p_maker) else $error("wrong maker code");
endmodule : bpcer_link_monitor

// ---- test/bpcer_tb.sv ----
// testbench: apb traffic through the host end into the device end
`timescale 1ns/1ps
module bpcer_tb;
    logic clk = 1'b0, arst_n = 1'b0, sel = 1'b0, en = 1'b0, wen = 1'b0, fv = 1'b0, fb = 1'b0, fd = 1'b0;
    logic [11:0] pa = 12'h000;
    logic [31:0] pd = 32'h00000000, prd, t;
    logic rdy, err, perr, lreq;
    logic [8:0] lblk;
    logic [5:0] lpg;
    logic [9:0] fa = 10'h000;
    logic [15:0] fdat = 16'h0000;
    logic [1:0] s0 = 2'h0, s1 = 2'h0;
    logic [2:0] prot = 3'h0;
    int num_errors = 0, tests_run = 0, loads = 0;
    bpcer_link_if link ();
    bpcer_host bpcer_host_inst (.CLK(clk), .ARST_N(arst_n), .LINK(link.host), .PSEL(sel), .PENABLE(en),
        .PWRITE(wen), .PADDR(pa), .PWDATA(pd), .PRDATA(prd), .PREADY(rdy), .PSLVERR(err));
    bpcer_device bpcer_device_inst (.CLK(clk), .ARST_N(arst_n), .LINK(link.device), .LOAD_REQ(lreq),
        .LOAD_BLOCK(lblk), .LOAD_PAGE(lpg), .FILL_VALID(fv), .FILL_BOOT(fb), .FILL_ADDR(fa), .FILL_DATA(fdat),
        .FILL_DONE(fd), .ECC_STATUS_IN(8'h21), .FIRST_SECTOR_ERROR_WORD(8'hc3), .FIRST_SECTOR_ERROR_LINE(4'h9),
        .FIRST_SECTOR_SPARE_POSITION(s0), .SECOND_SECTOR_ERROR_WORD(8'h5e), .SECOND_SECTOR_ERROR_LINE(4'h6),
        .SECOND_SECTOR_SPARE_POSITION(s1), .PROTECT_STATUS(prot));
    bpcer_link_monitor bpcer_link_monitor_inst (.CLK(clk), .ARST_N(arst_n), .addr(link.addr),
        .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata), .rvalid(link.rvalid), .busy(link.busy));
    // clock and load request counter
    initial forever #20 clk = ~clk;
    always @(posedge clk) if (lreq === 1'b1) loads++;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : stop_test
    // one apb transfer held until pready, then an idle cycle
    task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
        int n;
        sel <= 1'b1;
        wen <= w;
        pa <= a;
        pd <= {16'h0000, d};
        @(posedge clk);
        en <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rdy !== 1'b1 && n < 64);
        t = prd;
        perr = err;
        sel <= 1'b0;
        en <= 1'b0;
        if (rdy !== 1'b1) begin
            num_errors++;
            stop_test();
        end
        @(posedge clk);
    endtask : apb
    task automatic dwr(input logic [15:0] a, input logic [15:0] d);
        apb(1'b1, 12'h000, a);
        apb(1'b1, 12'h004, d);
    endtask : dwr
    // device read: launch, poll pending, fetch and compare
    task automatic rc(input logic [15:0] a, input logic [15:0] exp);
        int n;
        apb(1'b1, 12'h000, a);
        apb(1'b1, 12'h008, 16'h0000);
        for (n = 0; n < 8 && !(n > 0 && t[0] === 1'b0); n++) apb(1'b0, 12'h00c, 16'h0000);
        if (t[0] !== 1'b0) begin
            num_errors++;
            stop_test();
        end
        apb(1'b0, 12'h008, 16'h0000);
        chk(t[15:0], exp);
    endtask : rc
    task automatic fill(input logic b, input logic [9:0] a, input logic [15:0] d, input logic done);
        fb <= b;
        fa <= a;
        fdat <= d;
        fv <= !done;
        fd <= done;
        @(posedge clk);
        fv <= 1'b0;
        fd <= 1'b0;
        @(posedge clk);
    endtask : fill
    task automatic t_boot;
        for (int i = 1; i < 5; i++) rc(16'hff00 + 16'(i), 16'h0000);
        fill(1'b1, 10'd517, 16'h1234, 1'b0);
        rc(16'h8005, 16'h1234);
        for (int i = 0; i < 2; i++) begin
            s0 <= 2'(i);
            s1 <= 2'(1 - i);
            fill(1'b1, 10'h000, 16'h0000, 1'b1);
            rc(16'hff01, 16'h0c39);
            rc(16'hff02, {10'h000, 2'(i), 4'h9});
            rc(16'hff03, 16'h05e6);
            rc(16'hff04, {10'h000, 2'(1 - i), 4'h6});
        end
        rc(16'hff00, 16'h0021);
        apb(1'b0, 12'h010, 16'h0000);
        chk({15'h0000, perr}, 16'h0001);
    endtask : t_boot
    task automatic t_data;
        dwr(16'h0210, 16'hbeef);
        rc(16'h0210, 16'hbeef);
        dwr(16'h0300, 16'h00e0);
        dwr(16'h0301, 16'h0000);
        rc(16'h0300, 16'h00e0);
        rc(16'h8005, 16'h1234);
        chk(16'(loads), 16'h0000);
    endtask : t_data
    task automatic t_ident;
        prot <= 3'h5;
        dwr(16'hf100, 16'h0003);
        dwr(16'h0000, 16'h0090);
        rc(16'h0000, bpcer_pkg::MAKER_CODE);
        rc(16'h0001, bpcer_pkg::DEVICE_CODE);
        rc(16'h0002, 16'h0005);
        rc(16'hff01, 16'h0000);
        dwr(16'h0211, 16'h0000);
        rc(16'h0001, 16'h0000);
        dwr(16'h01ff, 16'h00f0);
        rc(16'h8005, 16'h1234);
        rc(16'hf100, 16'h0000);
    endtask : t_ident
    task automatic t_load;
        dwr(16'hf241, 16'h0000);
        rc(16'hf241, 16'h0000);
        dwr(16'hf100, 16'h0005);
        dwr(16'hf107, 16'h00fe);
        dwr(16'hf200, 16'h0a03);
        dwr(16'h8003, 16'h00e0);
        dwr(16'h8003, 16'h1234);
        dwr(16'h8003, 16'h0000);
        rc(16'hf107, 16'h00fe);
        chk(16'(loads), 16'h0000);
        dwr(16'h8003, 16'h00e0);
        dwr(16'h01ff, 16'h0000);
        for (int n = 0; n < 16 && loads == 0; n++) @(posedge clk);
        if (loads == 0) begin
            num_errors++;
            stop_test();
        end
        chk(16'(loads), 16'h0001);
        chk({1'b0, lblk, lpg}, 16'h017f);
        rc(16'h8003, 16'h8000);
        rc(16'hf200, 16'h0a03);
        fill(1'b0, 10'h010, 16'h5a5a, 1'b0);
        fill(1'b0, 10'h000, 16'h0000, 1'b1);
        rc(16'h0210, 16'h5a5a);
        rc(16'hf107, 16'h0002);
        rc(16'hf100, 16'h0005);
        rc(16'hf241, 16'h0080);
        rc(16'hff01, 16'h0c39);
    endtask : t_load
    // reset, scenarios, verdict
    initial begin
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        t_boot();
        t_data();
        t_ident();
        t_load();
        stop_test();
    end
endmodule : bpcer_tb
